// >>> design/lpcc_defs.svh
`ifndef LPCC_DEFS_SVH
`define LPCC_DEFS_SVH

// Register byte offsets.
`define LPCC_CFG1_OFFSET 8'h00
`define LPCC_CFG2_OFFSET 8'h04
`define LPCC_TRIM_OFFSET 8'h08
`define LPCC_CTRL_OFFSET 8'h0C
`define LPCC_STAT_OFFSET 8'h10
`define LPCC_BRK_OFFSET 8'h14
`define LPCC_EXT_OFFSET 8'h18

// Field positions.
`define LPCC_CFG1_STOP_EN 0
`define LPCC_CFG1_WDOG_EN 1
`define LPCC_CFG1_SHORT_REC 2
`define LPCC_CTRL_WDOG_SVC 0
`define LPCC_EXT_MASK 0
`define LPCC_EXT_ENABLE 1

// Reset values.
`define LPCC_CFG1_RESET 3'h3
`define LPCC_CFG2_RESET 2'h0
`define LPCC_TRIM_RESET 8'h80
`define LPCC_EXT_RESET 2'h3
`define LPCC_BRK_RESET 16'h0000

// Timing.
`define LPCC_ACLK_MHZ 100
`define LPCC_INT_OSC_MHZ 16
`define LPCC_ACC_BITS 16
`define LPCC_INT_OSC_STEP ((`LPCC_INT_OSC_MHZ * (1 << `LPCC_ACC_BITS)) / `LPCC_ACLK_MHZ)
`define LPCC_STOP_REC_LONG 4096
`define LPCC_STOP_REC_SHORT 32
`define LPCC_RST_PIN_CYCLES 32

`endif

// >>> design/lpcc_pkg.sv
package lpcc_pkg;

  typedef enum logic [3:0] {
    LPCC_RUN = 4'b0001,
    LPCC_WAIT = 4'b0010,
    LPCC_STOP = 4'b0100,
    LPCC_RECOVER = 4'b1000
  } lpcc_state_type;

  typedef enum logic [1:0] {
    LPCC_SRC_INTERNAL = 2'b00,
    LPCC_SRC_RC = 2'b01,
    LPCC_SRC_CRYSTAL = 2'b10,
    LPCC_SRC_CRYSTAL_ALT = 2'b11
  } lpcc_src_type;

endpackage

// >>> design/lpcc_clk_div.sv
`timescale 1ns/10ps
// Divides the fast source tick by two and by four into tick enables.
module lpcc_clk_div
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fast_tick,
  output logic half_tick,
  output logic bus_tick
);

  logic [1:0] phase_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 2'h0;
    end
    else if (fast_tick)
    begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_tick <= 1'b0;
      bus_tick <= 1'b0;
    end
    else
    begin
      half_tick <= fast_tick & phase_q[0];
      bus_tick <= fast_tick & (phase_q == 2'h3);
    end
  end

endmodule

// >>> design/lpcc_top.sv
`timescale 1ns/10ps
`include "lpcc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Break stays inactive in stop; registers kept.
// - Wait clears mask; reset wake sets it.
// - Stop clears mask; reset wake sets it.
// - Wait and stop gate off CPU clock.
// - After stop, CPU clock restarts only after stabilisation delay.
// - Recovery lasts 4096 ticks, or 32 short.
// - Recovery counter cleared through stop, then times.
// - Watchdog runs in wait, resets on timeout.
// - Stop removes watchdog clock, clears prescaler.
// - Stop enable bit gates the stop instruction.
// - Unmasked enabled external request wakes from wait.
// - Unmasked external request wakes from stop.
// - Internal oscillator nominal 16 MHz, trimmable.
// - Fast clock is selected source; clocks watchdog.
// - Half clock halves; bus clock is quarter.
// - Wait leaves oscillator and fast, half and bus clocks running.
// - Stop disables selected oscillator and clocks.
// - Break state keeps oscillator clocks running.
// - Two select bits choose source; defined reset.
// - Interrupts taken after instruction, lowest index first.
// - Entry sets mask, loads vector.
// - Every internal reset drives reset pin low.
module lpcc_top
#(
  parameter int NUM_IRQ = 8,
  parameter int STOP_REC_LONG = `LPCC_STOP_REC_LONG,
  parameter int WDOG_PRESCALE_BITS = 8,
  parameter int WDOG_TIMEOUT = 1024
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic crystal_osc_clock,
  input wire logic resistor_cap_osc_clock,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic instr_done,
  input wire logic return_from_interrupt,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic ext_irq_request,
  input wire logic break_request,
  output logic fast_source_clock,
  output logic half_source_clock,
  output logic bus_clock,
  output logic cpu_clock,
  output logic watchdog_clock_input,
  output logic interrupt_mask,
  output logic int_entry,
  output logic [$clog2(NUM_IRQ+1)-1:0] int_vector,
  output logic internal_reset,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic break_active
);
  import lpcc_pkg::*;

  localparam int VW = $clog2(NUM_IRQ + 1);
  localparam logic [15:0] OSC_STEP = 16'(`LPCC_INT_OSC_STEP);

  lpcc_state_type state_q;
  logic [2:0] cfg1_q;
  lpcc_src_type cfg2_q;
  logic [7:0] trim_q;
  logic [1:0] ext_q;
  logic [15:0] brk_q;
  logic [16:0] osc_acc_q;
  logic int_tick;
  logic src_tick;
  logic fast_d;
  logic half_tick;
  logic bus_tick;
  logic [12:0] rec_cnt_q;
  logic [12:0] rec_target;
  logic [WDOG_PRESCALE_BITS-1:0] wd_pre_q;
  logic [15:0] wd_cnt_q;
  logic wd_timeout;
  logic wd_service;
  logic [5:0] rst_cnt_q;
  logic ext_wake;
  logic [NUM_IRQ:0] req_all;
  logic [VW-1:0] win_idx;
  logic win_any;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_fire;
  logic wr_ok;
  logic wstrb0_q;

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator sources and clock enables.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_acc_q <= 17'h0_0000;
    end
    else if (state_q != LPCC_STOP)
    begin
      osc_acc_q <= {1'b0, osc_acc_q[15:0]} + {1'b0, OSC_STEP}
                   + {{10{~trim_q[7]}}, trim_q[6:0]} + 17'h0_0001;
    end
  end

  assign int_tick = osc_acc_q[16];

  always_comb
  begin
    unique case (cfg2_q)
      LPCC_SRC_INTERNAL: src_tick = int_tick;
      LPCC_SRC_RC: src_tick = resistor_cap_osc_clock;
      LPCC_SRC_CRYSTAL: src_tick = crystal_osc_clock;
      LPCC_SRC_CRYSTAL_ALT: src_tick = crystal_osc_clock;
    endcase
  end

  // The oscillator runs in wait, break and recovery, and only stop gates it.
  assign fast_d = src_tick & (state_q != LPCC_STOP);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_source_clock <= 1'b0;
      half_source_clock <= 1'b0;
      bus_clock <= 1'b0;
      cpu_clock <= 1'b0;
    end
    else
    begin
      fast_source_clock <= fast_d;
      half_source_clock <= half_tick;
      bus_clock <= bus_tick;
      cpu_clock <= bus_tick & (state_q == LPCC_RUN) & ~internal_reset;
    end
  end

  lpcc_clk_div u_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .fast_tick(fast_d),
    .half_tick(half_tick),
    .bus_tick(bus_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Low-power state machine and stop recovery.

  assign ext_wake = ext_irq_request & ~ext_q[`LPCC_EXT_MASK];
  assign rec_target = cfg1_q[`LPCC_CFG1_SHORT_REC] ? 13'(`LPCC_STOP_REC_SHORT)
                      : 13'(STOP_REC_LONG);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= LPCC_RUN;
    end
    else if (wd_timeout)
    begin
      state_q <= LPCC_RUN;
    end
    else
    begin
      unique case (state_q)
        LPCC_RUN:
        begin
          if (stop_exec && cfg1_q[`LPCC_CFG1_STOP_EN])
          begin
            state_q <= LPCC_STOP;
          end
          else if (wait_exec)
          begin
            state_q <= LPCC_WAIT;
          end
        end
        LPCC_WAIT:
        begin
          if ((ext_wake && ext_q[`LPCC_EXT_ENABLE]) || (|irq_pending))
          begin
            state_q <= LPCC_RUN;
          end
        end
        LPCC_STOP:
        begin
          if (ext_wake)
          begin
            state_q <= LPCC_RECOVER;
          end
        end
        LPCC_RECOVER:
        begin
          if (fast_d && rec_cnt_q == rec_target - 13'h0001)
          begin
            state_q <= LPCC_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_q != LPCC_RECOVER)
    begin
      rec_cnt_q <= 13'h0000;
    end
    else if (fast_d)
    begin
      rec_cnt_q <= rec_cnt_q + 13'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog and internal reset.

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_q == LPCC_STOP)
    begin
      wd_pre_q <= '0;
      watchdog_clock_input <= 1'b0;
    end
    else
    begin
      wd_pre_q <= fast_d ? wd_pre_q + 1'b1 : wd_pre_q;
      watchdog_clock_input <= fast_d & (&wd_pre_q);
    end
  end

  assign wd_timeout = cfg1_q[`LPCC_CFG1_WDOG_EN] && watchdog_clock_input
                      && wd_cnt_q == 16'(WDOG_TIMEOUT - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || wd_service || wd_timeout || !cfg1_q[`LPCC_CFG1_WDOG_EN])
    begin
      wd_cnt_q <= 16'h0000;
    end
    else if (watchdog_clock_input)
    begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_cnt_q <= 6'h00;
      internal_reset <= 1'b0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
    end
    else
    begin
      if (wd_timeout)
      begin
        rst_cnt_q <= 6'(`LPCC_RST_PIN_CYCLES - 1);
      end
      else if (rst_cnt_q != 6'h00)
      begin
        rst_cnt_q <= rst_cnt_q - 6'h01;
      end
      internal_reset <= wd_timeout || rst_cnt_q > 6'h01;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= wd_timeout || rst_cnt_q > 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt mask and arbitration.

  assign req_all = {irq_pending, ext_wake & ext_q[`LPCC_EXT_ENABLE]};

  always_comb
  begin
    win_idx = '0;
    win_any = 1'b0;
    for (int i = NUM_IRQ; i >= 0; i--)
    begin
      if (req_all[i])
      begin
        win_idx = VW'(i);
        win_any = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      interrupt_mask <= 1'b1;
      int_entry <= 1'b0;
      int_vector <= '0;
    end
    else
    begin
      int_entry <= 1'b0;
      if (wd_timeout)
      begin
        interrupt_mask <= 1'b1;
      end
      else if (state_q == LPCC_RUN && stop_exec && cfg1_q[`LPCC_CFG1_STOP_EN])
      begin
        interrupt_mask <= 1'b0;
      end
      else if (state_q == LPCC_RUN && wait_exec)
      begin
        interrupt_mask <= 1'b0;
      end
      else if (state_q == LPCC_RUN && instr_done && !interrupt_mask && win_any)
      begin
        interrupt_mask <= 1'b1;
        int_entry <= 1'b1;
        int_vector <= win_idx;
      end
      else if (return_from_interrupt)
      begin
        interrupt_mask <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Break state.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      break_active <= 1'b0;
    end
    else
    begin
      break_active <= break_request & (state_q != LPCC_STOP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave.

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ok = awaddr_q == `LPCC_CFG1_OFFSET || awaddr_q == `LPCC_CFG2_OFFSET
                 || awaddr_q == `LPCC_TRIM_OFFSET || awaddr_q == `LPCC_CTRL_OFFSET
                 || awaddr_q == `LPCC_STAT_OFFSET || awaddr_q == `LPCC_BRK_OFFSET
                 || awaddr_q == `LPCC_EXT_OFFSET;
  assign wd_service = wr_fire && awaddr_q == `LPCC_CTRL_OFFSET && wdata_q[`LPCC_CTRL_WDOG_SVC];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Stop entry does not touch these registers, break address included.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg1_q <= `LPCC_CFG1_RESET;
      cfg2_q <= lpcc_src_type'(`LPCC_CFG2_RESET);
      trim_q <= `LPCC_TRIM_RESET;
      ext_q <= `LPCC_EXT_RESET;
      brk_q <= `LPCC_BRK_RESET;
    end
    else if (wr_fire && wstrb0_q)
    begin
      if (awaddr_q == `LPCC_CFG1_OFFSET)
      begin
        cfg1_q <= wdata_q[2:0];
      end
      if (awaddr_q == `LPCC_CFG2_OFFSET)
      begin
        cfg2_q <= lpcc_src_type'(wdata_q[1:0]);
      end
      if (awaddr_q == `LPCC_TRIM_OFFSET)
      begin
        trim_q <= wdata_q[7:0];
      end
      if (awaddr_q == `LPCC_EXT_OFFSET)
      begin
        ext_q <= wdata_q[1:0];
      end
      if (awaddr_q == `LPCC_BRK_OFFSET)
      begin
        brk_q <= wdata_q[15:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case ({s_axi_araddr[7:2], 2'h0})
          `LPCC_CFG1_OFFSET: s_axi_rdata <= {29'h0, cfg1_q};
          `LPCC_CFG2_OFFSET: s_axi_rdata <= {30'h0, cfg2_q};
          `LPCC_TRIM_OFFSET: s_axi_rdata <= {24'h0, trim_q};
          `LPCC_CTRL_OFFSET: s_axi_rdata <= 32'h0000_0000;
          `LPCC_STAT_OFFSET: s_axi_rdata <= {16'h0, wd_cnt_q[7:0], 1'b0,
                                             internal_reset, break_active,
                                             interrupt_mask, state_q};
          `LPCC_BRK_OFFSET: s_axi_rdata <= {16'h0, brk_q};
          `LPCC_EXT_OFFSET: s_axi_rdata <= {30'h0, ext_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> test/lpcc_osc_model.sv
`timescale 1ns/10ps
////////////////////////////////////////
// Free-running crystal and RC sources, given as one-cycle ticks.
module lpcc_osc_model
(
  input wire logic aclk,
  output bit crystal_osc_clock,
  output bit resistor_cap_osc_clock
);
  int cnt_q;
  always_ff @(posedge aclk)
  begin
    cnt_q <= (cnt_q + 1) % 35;
    crystal_osc_clock <= cnt_q % 5 == 0;
    resistor_cap_osc_clock <= cnt_q % 7 == 0;
  end
endmodule

// >>> test/lpcc_assertions.sv
`timescale 1ns/10ps
////////////////////////////////////////
// Watches clock, mask, interrupt and reset outputs.
module lpcc_checker
#(
  parameter int NUM_IRQ = 8
)
(
  input logic aclk,
  input logic aresetn,
  input logic wait_exec,
  input logic instr_done,
  input logic [NUM_IRQ-1:0] irq_pending,
  input logic ext_irq_request,
  input logic break_request,
  input logic fast_source_clock,
  input logic half_source_clock,
  input logic bus_clock,
  input logic cpu_clock,
  input logic interrupt_mask,
  input logic int_entry,
  input logic [$clog2(NUM_IRQ+1)-1:0] int_vector,
  input logic internal_reset,
  input logic reset_pin_out,
  input logic reset_pin_oe,
  input logic break_active
);
  logic [1:0] fc_q;
  logic [1:0] hc_q;
  logic [5:0] oe_q;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Fast ticks since the last half tick.
  always_ff @(posedge aclk)
    if (!aresetn || half_source_clock)
      fc_q <= {1'b0, fast_source_clock & aresetn};
    else
      fc_q <= fc_q + {1'b0, fast_source_clock};
  // Half ticks since the last bus tick; a half tick beside a bus tick closes its group.
  always_ff @(posedge aclk)
    if (!aresetn || bus_clock)
      hc_q <= 2'h0;
    else
      hc_q <= hc_q + {1'b0, half_source_clock};
  // Length of the reset pin drive.
  always_ff @(posedge aclk)
    if (!aresetn || !reset_pin_oe)
      oe_q <= 6'h00;
    else
      oe_q <= oe_q + 6'h01;
  ////////////////////////////////////////
  AST_HALF_RATE:
    assert property (half_source_clock |-> fc_q + fast_source_clock == 2)
    else $error("half tick off rate");
  AST_BUS_RATE:
    assert property (bus_clock |-> hc_q + half_source_clock == 2)
    else $error("bus tick off rate");
  AST_WAIT_GATE:
    assert property (wait_exec ##1 (!ext_irq_request && irq_pending == 0
      && !internal_reset) [*2] |-> !cpu_clock)
    else $error("cpu clock runs in wait");
  AST_WAIT_MASK:
    assert property (wait_exec && !internal_reset |=> !interrupt_mask)
    else $error("wait left mask set");
  AST_ENTRY_MASK:
    assert property (int_entry |-> interrupt_mask && !$past(interrupt_mask))
    else $error("entry without mask set");
  AST_PRIORITY:
    assert property (instr_done && !interrupt_mask && !ext_irq_request
      && irq_pending[0] |=> int_entry && int_vector == 1)
    else $error("wrong entry vector");
  AST_PIN_DRIVE:
    assert property (internal_reset |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven low");
  AST_PIN_LEN:
    assert property ($fell(reset_pin_oe) |-> oe_q == 31)
    else $error("reset pin drive length");
  AST_RESET_MASK:
    assert property ($fell(internal_reset) |-> interrupt_mask)
    else $error("mask clear after reset");
  AST_BREAK_OFF:
    assert property (!break_request |=> !break_active)
    else $error("break active without request");
  COV_ENTRY: cover property (int_entry);
  COV_PIN: cover property ($fell(reset_pin_oe));
  COV_WAIT: cover property (wait_exec);
endmodule
bind lpcc_top lpcc_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.*);

// >>> test/low_power_clock_control_tb.sv
`timescale 1ns/10ps
module low_power_clock_control_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, irq_pending;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, int_vector;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic crystal_osc_clock, resistor_cap_osc_clock, wait_exec, stop_exec, instr_done;
  logic return_from_interrupt, ext_irq_request, break_request, fast_source_clock;
  logic half_source_clock, bus_clock, cpu_clock, watchdog_clock_input, interrupt_mask;
  logic int_entry, internal_reset, reset_pin_out, reset_pin_oe, break_active;
  int num_errors, cmp_count, n, f, c, w;
  logic [7:0] row_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C};
  logic [7:0] row_d [7] = '{8'h03, 8'h00, 8'h80, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [1:0] row_r [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  lpcc_top #(.STOP_REC_LONG(40), .WDOG_PRESCALE_BITS(2), .WDOG_TIMEOUT(4)) dut (.*);
  lpcc_osc_model u_osc (.*);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value at %0t: %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask
  task lim();
    if (n >= 3000)
    begin
      $display("wrong value at %0t: %h expected %h", $time, n, 0);
      num_errors++;
      conclude();
    end
  endtask
  task axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 3000);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    lim();
    @(posedge aclk);
  endtask
  task axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 3000);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    lim();
    @(posedge aclk);
  endtask
  // Counts fast, cpu and watchdog ticks over k cycles.
  task tick(input int k);
    f = 0;
    c = 0;
    w = 0;
    repeat (k)
    begin
      @(posedge aclk);
      f += fast_source_clock;
      c += cpu_clock;
      w += watchdog_clock_input;
    end
  endtask
  // Waits for a cpu tick, counting fast ticks meanwhile.
  task wcpu();
    n = 0;
    f = 0;
    while (cpu_clock !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
      f += fast_source_clock;
    end
    lim();
  endtask
  ////////////////////////////////////////
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, irq_pending, s_axi_wdata} = '0;
    {wait_exec, stop_exec, instr_done, return_from_interrupt} = '0;
    {ext_irq_request, break_request} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(interrupt_mask, 1);
    for (int i = 0; i < 7; i++)
    begin
      axr(row_a[i]);
      chk(rd, {24'h00_0000, row_d[i]});
      chk(rr, row_r[i]);
    end
    $display("test registers done");
    axw(8'h00, 8'h04);
    stop_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    tick(40);
    chk(c > 0, 1);
    chk(interrupt_mask, 1);
    axw(8'h1C, 8'h07);
    chk(rr, 2'h2);
    axw(8'h04, 8'h01);
    chk(rr, 2'h0);
    tick(70);
    chk(f >= 9 && f <= 11, 1);
    axw(8'h04, 8'h02);
    tick(70);
    chk(f >= 13 && f <= 15, 1);
    axw(8'h04, 8'h00);
    tick(200);
    chk(f >= 31 && f <= 33, 1);
    axw(8'h08, 8'h00);
    tick(1000);
    chk(f >= 157 && f <= 159, 1);
    axw(8'h08, 8'h80);
    $display("test sources done");
    axw(8'h00, 8'h05);
    axw(8'h18, 8'h02);
    wait_exec <= 1'b1;
    @(posedge aclk);
    wait_exec <= 1'b0;
    @(posedge aclk);
    tick(60);
    chk(c, 0);
    chk(f > 0 && w > 0, 1);
    ext_irq_request <= 1'b1;
    wcpu();
    chk(interrupt_mask, 0);
    $display("test wait done");
    for (int i = 0; i < 3; i++)
    begin
      irq_pending <= i == 0 ? 8'h01 : 8'h05;
      instr_done <= 1'b1;
      @(posedge aclk);
      instr_done <= 1'b0;
      @(posedge aclk);
      chk(int_entry, i != 1);
      chk(int_vector, i == 2);
      chk(interrupt_mask, 1);
      ext_irq_request <= 1'b0;
      return_from_interrupt <= i == 1;
      @(posedge aclk);
      return_from_interrupt <= 1'b0;
    end
    irq_pending <= 8'h00;
    $display("test interrupt done");
    break_request <= 1'b1;
    tick(20);
    chk(break_active && f > 0, 1);
    for (int i = 0; i < 2; i++)
    begin
      axw(8'h00, i == 0 ? 8'h05 : 8'h01);
      axw(8'h14, 8'h5A);
      axw(8'h0C, 8'h01);
      stop_exec <= 1'b1;
      @(posedge aclk);
      stop_exec <= 1'b0;
      tick(2);
      chk(interrupt_mask, 0);
      tick(60);
      chk(f + c + w, 0);
      chk(break_active, 0);
      ext_irq_request <= 1'b1;
      wcpu();
      chk(f >= (i == 0 ? 32 : 40) && f <= (i == 0 ? 38 : 46), 1);
      chk(interrupt_mask, 0);
      ext_irq_request <= 1'b0;
      axr(8'h14);
      chk(rd, 32'h0000_005A);
    end
    break_request <= 1'b0;
    $display("test stop done");
    axw(8'h00, 8'h07);
    wait_exec <= 1'b1;
    @(posedge aclk);
    wait_exec <= 1'b0;
    n = 0;
    while (internal_reset !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    lim();
    chk(reset_pin_oe, 1);
    wcpu();
    chk(interrupt_mask, 1);
    axw(8'h00, 8'h05);
    $display("test watchdog done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    f = 0;
    while (bus_clock !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
      f += fast_source_clock;
    end
    lim();
    chk(f, 4);
    chk(interrupt_mask, 1);
    axr(8'h00);
    chk(rd, 32'h0000_0003);
    $display("test reset done");
    conclude();
  end
endmodule
